/* File: pmdc_pkg.sv */
// Shared constants and types of the PWM mode and dead-time control block
`default_nettype none
package pmdc_pkg;
    localparam int unsigned PMDC_NCH   = 8;
    localparam int unsigned PMDC_NPAIR = 4;
    localparam int unsigned PMDC_AW    = 8;
    localparam int unsigned PMDC_DW    = 32;
    localparam int unsigned PMDC_PW    = 16;
    localparam int unsigned PMDC_ZW    = 8;
    localparam logic [7:0]  PMDC_OFF_PERIOD0 = 8'h0C;
    localparam logic [7:0]  PMDC_OFF_PERIOD7 = 8'h28;
    localparam logic [7:0]  PMDC_OFF_CTL2    = 8'h4C;
    localparam logic [7:0]  PMDC_OFF_FLAG    = 8'h50;
    localparam logic [7:0]  PMDC_OFF_INTEN   = 8'h54;
    localparam logic [7:0]  PMDC_OFF_INTSTS  = 8'h58;
    localparam int unsigned PMDC_BIT_ALIGN   = 31;
    localparam int unsigned PMDC_BIT_GROUP   = 30;
    localparam int unsigned PMDC_BIT_MODE    = 28;
    localparam int unsigned PMDC_BIT_DT      = 24;
    localparam int unsigned PMDC_BIT_ZSRC    = 17;
    localparam int unsigned PMDC_GROUPED     = 6;
    localparam logic [31:0] PMDC_CTL2_RESET  = 32'h00000000;
    localparam logic [31:0] PMDC_CTL2_MASK   = 32'hFF020000;
    localparam logic [31:0] PMDC_ZERO32      = 32'h00000000;
    typedef enum logic [1:0] {
        PMDC_MODE_INDEP = 2'b00,
        PMDC_MODE_COMP  = 2'b01,
        PMDC_MODE_SYNC  = 2'b10,
        PMDC_MODE_RSVD  = 2'b11
    } pmdc_mode_t;
    typedef enum logic {
        PMDC_UP   = 1'b0,
        PMDC_DOWN = 1'b1
    } pmdc_dir_t;
endpackage : pmdc_pkg
`default_nettype wire

/* File: pmdc_ch_if.sv */
// Signals between the control top and one channel counter
`default_nettype none
interface pmdc_ch_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic                         tick;
    logic                         center;
    logic [pmdc_pkg::PMDC_PW-1:0] period;
    logic                         zero_evt;
    logic                         period_evt;
    logic                         wave;
    modport ctl (input pclk, input presetn, output tick, output center, output period,
                 input zero_evt, input period_evt, input wave);
    modport count_side (input pclk, input presetn, input tick, input center, input period,
                        output zero_evt, output period_evt, output wave);
endinterface : pmdc_ch_if
`default_nettype wire

/* File: pmdc_channel.sv */
// One channel counter, edge- or center-aligned
`default_nettype none
module pmdc_channel (
    pmdc_ch_if.count_side ch
);
    import pmdc_pkg::*;
    localparam logic [PMDC_PW-1:0] CNT_ZERO = '0;
    localparam logic [PMDC_PW-1:0] CNT_ONE  = PMDC_PW'(1);
    logic [PMDC_PW-1:0] cnt;
    logic [PMDC_PW-1:0] next_cnt;
    pmdc_dir_t          dir;
    pmdc_dir_t          next_dir;

    always_comb begin
        next_cnt = cnt;
        next_dir = dir;
        if (ch.tick) begin
            if (ch.period == CNT_ZERO) begin
                next_cnt = CNT_ZERO;
                next_dir = PMDC_UP;
            end else if (!ch.center) begin
                next_dir = PMDC_DOWN;
                next_cnt = (cnt == CNT_ZERO) ? ch.period : cnt - CNT_ONE;
            end else begin
                // Up 0..P then down P-1..0: 2P+1 ticks a cycle
                case (dir)
                    PMDC_UP: begin
                        if (cnt >= ch.period) begin
                            next_dir = PMDC_DOWN;
                            next_cnt = ch.period - CNT_ONE;
                        end else begin
                            next_cnt = cnt + CNT_ONE;
                        end
                    end
                    PMDC_DOWN: begin
                        if (cnt == CNT_ZERO) begin
                            next_dir = PMDC_UP;
                        end else begin
                            next_cnt = cnt - CNT_ONE;
                        end
                    end
                    default: begin
                        next_dir = PMDC_UP;
                        next_cnt = CNT_ZERO;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ch.pclk or negedge ch.presetn) begin
        if (!ch.presetn) begin
            cnt <= CNT_ZERO;
            dir <= PMDC_UP;
        end else begin
            cnt <= next_cnt;
            dir <= next_dir;
        end
    end

    // Underflow: down count sitting at zero
    assign ch.zero_evt   = ch.tick && (ch.period != CNT_ZERO) && (cnt == CNT_ZERO)
                           && (!ch.center || dir == PMDC_DOWN);
    assign ch.period_evt = ch.tick && (ch.period != CNT_ZERO) && (cnt == ch.period)
                           && (!ch.center || dir == PMDC_UP);
    // Zero period keeps the wave low
    assign ch.wave = (ch.period != CNT_ZERO)
                     && (ch.center ? (dir == PMDC_DOWN) : (cnt <= (ch.period >> 1)));

    property p_turn_down;
        @(posedge ch.pclk) disable iff (!ch.presetn)
        (ch.tick && ch.center && ch.period != CNT_ZERO && dir == PMDC_UP
         && cnt == ch.period) |=> (dir == PMDC_DOWN && cnt == $past(ch.period) - CNT_ONE);
    endproperty
    a_turn_down: assert property (p_turn_down) else $error("no turn at period");
endmodule : pmdc_channel
`default_nettype wire

/* File: pmdc_top.sv */
// PWM mode, channel grouping, dead-time and zero-point flag control with APB
`default_nettype none
// What this block does
// - Bit 31 picks edge or center alignment
// - Group off: every channel times independently
// - Group on: 0,2,4 and 1,3,5 share timing
// - Bits 27..24 enable dead-time complementary pairs
// - Select clear: zero flag on counter underflow
// - Select matters only in center alignment
// - Center frequency is tick over 2P+1
// - Zero flag set by hardware, write-one clears
module pmdc_top #(
    parameter int unsigned CLK_DIV   = 1,
    parameter int unsigned DT_CYCLES = 2
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           pclk_en,
    input  wire logic [pmdc_pkg::PMDC_AW-1:0]   paddr,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [pmdc_pkg::PMDC_DW-1:0]   pwdata,
    output logic      [pmdc_pkg::PMDC_DW-1:0]   prdata,
    output logic                                pready,
    output logic                                pslverr,
    output logic      [pmdc_pkg::PMDC_NCH-1:0]  pwm_out,
    output logic                                irq
);
    import pmdc_pkg::*;
    localparam int unsigned DIVW = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
    localparam int unsigned DTW  = $clog2(DT_CYCLES + 1);
    localparam logic [DIVW-1:0] DIV_LAST = DIVW'(CLK_DIV - 1);
    localparam logic [DTW-1:0]  DT_LOAD  = DTW'(DT_CYCLES);
    localparam logic [DTW-1:0]  DT_NONE  = '0;

    if (CLK_DIV < 1 || DT_CYCLES < 1) begin : g_bad_param
        $error("CLK_DIV and DT_CYCLES must be at least 1");
    end

    logic [PMDC_DW-1:0]  ctl2,   next_ctl2;
    logic [PMDC_PW-1:0]  period [PMDC_NCH];
    logic [PMDC_PW-1:0]  next_period [PMDC_NCH];
    logic [PMDC_ZW-1:0]  zf,     next_zf;
    logic [PMDC_ZW-1:0]  zif,    next_zif;
    logic [PMDC_ZW-1:0]  zien,   next_zien;
    logic [PMDC_DW-1:0]  next_prdata;
    logic                next_pready, next_pslverr, next_irq;
    logic [DIVW-1:0]     div_cnt, next_div_cnt;
    logic                tick,    next_tick;
    logic [DTW-1:0]      dt_cnt [PMDC_NPAIR];
    logic [DTW-1:0]      next_dt_cnt [PMDC_NPAIR];
    logic [PMDC_NPAIR-1:0] prev_we, next_prev_we;
    logic [PMDC_NCH-1:0] next_pwm_out;
    logic [PMDC_NCH-1:0] zero_ev, per_ev, wave, nz;
    logic [PMDC_NCH-1:0] eff_zero, eff_per, eff_wave, eff_nz, evt;
    logic                center, group_en, zsrc, wr, access, map_hit, per_hit;
    logic [2:0]          per_idx;
    logic [PMDC_NPAIR-1:0] dt_en;
    pmdc_mode_t          mode;

    assign center   = ctl2[PMDC_BIT_ALIGN];
    assign group_en = ctl2[PMDC_BIT_GROUP];
    assign mode     = pmdc_mode_t'(ctl2[PMDC_BIT_MODE +: 2]);
    assign dt_en    = ctl2[PMDC_BIT_DT +: PMDC_NPAIR];
    assign zsrc     = ctl2[PMDC_BIT_ZSRC];

    for (genvar g = 0; g < PMDC_NCH; g++) begin : g_ch
        pmdc_ch_if chi (.pclk(pclk), .presetn(presetn));
        // Gated so a frozen block stops its counters too
        assign chi.tick   = tick && pclk_en;
        assign chi.center = center;
        assign chi.period = period[g];
        assign zero_ev[g] = chi.zero_evt;
        assign per_ev[g]  = chi.period_evt;
        assign wave[g]    = chi.wave;
        assign nz[g]      = (period[g] != '0);
        pmdc_channel u_ch (.ch(chi.count_side));
        if (g < PMDC_GROUPED) begin : g_grp
            // Grouped channels borrow channel 0 or 1 timing
            assign eff_zero[g] = group_en ? zero_ev[g % 2] : zero_ev[g];
            assign eff_per[g]  = group_en ? per_ev[g % 2]  : per_ev[g];
            assign eff_wave[g] = group_en ? wave[g % 2]    : wave[g];
            assign eff_nz[g]   = group_en ? nz[g % 2]      : nz[g];
        end else begin : g_solo
            assign eff_zero[g] = zero_ev[g];
            assign eff_per[g]  = per_ev[g];
            assign eff_wave[g] = wave[g];
            assign eff_nz[g]   = nz[g];
        end
        // Period-match source only counts in center alignment
        assign evt[g] = (center && zsrc) ? eff_per[g] : eff_zero[g];
    end

    assign access  = psel && penable;
    assign wr      = access && pready && pwrite;
    assign per_hit = (paddr >= PMDC_OFF_PERIOD0) && (paddr <= PMDC_OFF_PERIOD7)
                     && (paddr[1:0] == 2'h0);
    assign per_idx = 3'((paddr - PMDC_OFF_PERIOD0) >> 2);
    assign map_hit = per_hit || paddr == PMDC_OFF_CTL2 || paddr == PMDC_OFF_FLAG
                     || paddr == PMDC_OFF_INTEN || paddr == PMDC_OFF_INTSTS;

    // Register file and APB answer
    always_comb begin
        next_ctl2    = ctl2;
        next_zien    = zien;
        next_period  = period;
        next_zf      = zf;
        next_zif     = zif;
        next_pready  = access && !pready;
        next_pslverr = access && !pready && !map_hit;
        next_prdata  = prdata;
        if (wr && paddr == PMDC_OFF_CTL2) begin
            next_ctl2 = pwdata & PMDC_CTL2_MASK;
        end
        if (wr && paddr == PMDC_OFF_INTEN) begin
            next_zien = pwdata[PMDC_ZW-1:0];
        end
        for (int i = 0; i < PMDC_NCH; i++) begin
            if (wr && per_hit && per_idx == 3'(i)) begin
                next_period[i] = pwdata[PMDC_PW-1:0];
            end
        end
        if (wr && paddr == PMDC_OFF_FLAG) begin
            next_zf = zf & ~pwdata[PMDC_ZW-1:0];
        end
        if (wr && paddr == PMDC_OFF_INTSTS) begin
            next_zif = zif & ~pwdata[PMDC_ZW-1:0];
        end
        // Set applied after clear so a same-cycle event survives
        next_zf  = next_zf | evt;
        next_zif = next_zif | evt;
        next_irq = |(next_zif & zien);
        if (access && !pready) begin
            next_prdata = PMDC_ZERO32;
            if (per_hit) begin
                next_prdata = {{(PMDC_DW - PMDC_PW){1'b0}}, period[per_idx]};
            end else if (paddr == PMDC_OFF_CTL2) begin
                next_prdata = ctl2;
            end else if (paddr == PMDC_OFF_FLAG) begin
                next_prdata = {{(PMDC_DW - PMDC_ZW){1'b0}}, zf};
            end else if (paddr == PMDC_OFF_INTEN) begin
                next_prdata = {{(PMDC_DW - PMDC_ZW){1'b0}}, zien};
            end else if (paddr == PMDC_OFF_INTSTS) begin
                next_prdata = {{(PMDC_DW - PMDC_ZW){1'b0}}, zif};
            end
        end
    end

    // Prescaled PWM tick
    always_comb begin
        next_tick    = (div_cnt == DIV_LAST);
        next_div_cnt = next_tick ? '0 : div_cnt + DIVW'(1);
    end

    // Pair output shaping; dead time counted in pclk cycles
    always_comb begin
        next_dt_cnt  = dt_cnt;
        next_prev_we = prev_we;
        next_pwm_out = pwm_out;
        for (int p = 0; p < PMDC_NPAIR; p++) begin
            next_prev_we[p] = eff_wave[2*p];
            if (dt_en[p] && eff_wave[2*p] != prev_we[p]) begin
                next_dt_cnt[p] = DT_LOAD;
            end else if (dt_cnt[p] != DT_NONE) begin
                next_dt_cnt[p] = dt_cnt[p] - DTW'(1);
            end
            if (dt_en[p]) begin
                // Both low during dead time so the pair never overlaps
                next_pwm_out[2*p]   = eff_wave[2*p] && next_dt_cnt[p] == DT_NONE;
                next_pwm_out[2*p+1] = !eff_wave[2*p] && eff_nz[2*p]
                                      && next_dt_cnt[p] == DT_NONE;
            end else begin
                next_pwm_out[2*p] = eff_wave[2*p];
                case (mode)
                    PMDC_MODE_COMP: next_pwm_out[2*p+1] = !eff_wave[2*p] && eff_nz[2*p];
                    PMDC_MODE_SYNC: next_pwm_out[2*p+1] = eff_wave[2*p];
                    default:        next_pwm_out[2*p+1] = eff_wave[2*p+1];
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl2    <= PMDC_CTL2_RESET;
            period  <= '{default: '0};
            zf      <= '0;
            zif     <= '0;
            zien    <= '0;
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
            div_cnt <= '0;
            tick    <= 1'b0;
            dt_cnt  <= '{default: '0};
            prev_we <= '0;
            pwm_out <= '0;
        end else if (pclk_en) begin
            ctl2    <= next_ctl2;
            period  <= next_period;
            zf      <= next_zf;
            zif     <= next_zif;
            zien    <= next_zien;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            irq     <= next_irq;
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
            dt_cnt  <= next_dt_cnt;
            prev_we <= next_prev_we;
            pwm_out <= next_pwm_out;
        end
    end

    sequence s_ctl2_write;
        wr && pclk_en && paddr == PMDC_OFF_CTL2;
    endsequence
    property p_ctl2_align;
        @(posedge pclk) disable iff (!presetn)
        s_ctl2_write |=> center == $past(pwdata[PMDC_BIT_ALIGN]);
    endproperty
    a_ctl2_align: assert property (p_ctl2_align) else $error("alignment bit lost");
    property p_indep;
        @(posedge pclk) disable iff (!presetn)
        !group_en |-> eff_zero[2] == zero_ev[2] && eff_wave[4] == wave[4];
    endproperty
    a_indep: assert property (p_indep) else $error("ungrouped channel borrows timing");
    property p_group;
        @(posedge pclk) disable iff (!presetn)
        group_en |-> eff_zero[4] == zero_ev[0] && eff_zero[5] == zero_ev[1]
                     && eff_wave[2] == wave[0] && eff_wave[3] == wave[1];
    endproperty
    a_group: assert property (p_group) else $error("grouped channel off its leader");
    property p_dead_gap;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && dt_en[0]) |=> !(pwm_out[0] && pwm_out[1]);
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("pair overlaps");
    property p_zero_set;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && zero_ev[6] && !(center && zsrc)) |=> zf[6] && zif[6];
    endproperty
    a_zero_set: assert property (p_zero_set) else $error("underflow flag missed");
    property p_match_set;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && center && zsrc && per_ev[7] && !zero_ev[7]) |=> zf[7];
    endproperty
    a_match_set: assert property (p_match_set) else $error("match flag missed");
    property p_edge_ignore;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && !center && zsrc && per_ev[7] && !zero_ev[7] && !zf[7]) |=> !zf[7];
    endproperty
    a_edge_ignore: assert property (p_edge_ignore) else $error("select used in edge");
    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && mode == PMDC_MODE_SYNC && !dt_en[3]) |=> pwm_out[7] == pwm_out[6];
    endproperty
    a_sync: assert property (p_sync) else $error("sync pair differs");
    sequence s_period_zero;
        (period[0] == '0 && !group_en) [*3];
    endsequence
    property p_period_zero;
        @(posedge pclk) disable iff (!presetn)
        s_period_zero |-> !pwm_out[0];
    endproperty
    a_period_zero: assert property (p_period_zero) else $error("zero period drives high");
    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (wr && pclk_en && paddr == PMDC_OFF_FLAG && pwdata[3] && evt[3]) |=> zf[3];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (wr && pclk_en && paddr == PMDC_OFF_FLAG && pwdata[3] && !evt[3]) |=> !zf[3];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");
endmodule : pmdc_top
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench of the PWM mode, grouping, dead-time and zero-point control block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmdc_pkg::*;
    localparam int unsigned CDIV  = 1;
    localparam int unsigned DT    = 2;
    localparam int          LIMIT = 60000;
    localparam logic [7:0]  PMDC_OFF_PERIOD1 = PMDC_OFF_PERIOD0 + 8'h04;
    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pwm_out;
    logic        irq;
    logic [31:0] rv;
    logic [31:0] v;
    logic        re;
    int          failures;
    int          compares;
    int          cycles;
    int          n;
    int          lo;
    int          hi;
    int          bad;
    // Zero-point cases: control value, clear on rise, expected flag
    logic [31:0] zc_ctl [5] = '{32'h00000000, 32'h00020000, 32'h80000000, 32'h80020000,
                                32'h80020000};
    logic        zc_first [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] zc_exp [5] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'h0};

    pmdc_top #(.CLK_DIV(CDIV), .DT_CYCLES(DT)) dut (
        .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq)
    );

    always #4 pclk = ~pclk;

    function automatic int f_per(input bit center, input int p);
        return center ? (2 * p + 1) * CDIV : (p + 1) * CDIV;
    endfunction : f_per

    function automatic logic f_odd(input int m, input logic e);
        return (m == 1) ? ~e : (m == 2) ? e : 1'b0;
    endfunction : f_odd

    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_n(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            failures++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_n

    task automatic step(input int c);
        repeat (c) @(posedge pclk);
    endtask : step

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk_n("apb answer", 1, int'(k < 50));
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rv, re);
    endtask : wr

    // Waits for a transition to lvl; k is the number of cycles spent
    task automatic wait_to(input int ch, input logic lvl, output int k);
        k = 0;
        while (pwm_out[ch] !== ~lvl && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        while (pwm_out[ch] !== lvl && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 3000) chk_n("pwm edge wait", 0, k);
    endtask : wait_to

    always @(posedge pclk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            failures++;
            summarize();
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {failures, compares, cycles} = '0;
        void'($urandom(66));
        step(20);
        presetn <= 1'b1;
        apb(1'b0, PMDC_OFF_CTL2, 32'h0, rv, re);
        chk("control reset", 32'h00000000, rv);
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            if (i < 4) v[29:28] = 2'(i);
            wr(PMDC_OFF_CTL2, v);
            apb(1'b0, PMDC_OFF_CTL2, 32'h0, rv, re);
            chk("control readback", v & 32'hFF020000, rv);
        end
        apb(1'b0, 8'h60, 32'h0, rv, re);
        chk("unmapped error", 32'h1, {31'h0, re});
        chk("unmapped data", 32'h0, rv);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            n = 2 + $urandom_range(13);
            wr(PMDC_OFF_CTL2, {i[0], 31'h0});
            wr(PMDC_OFF_PERIOD0, 32'(n));
            wait_to(0, 1'b1, lo);
            wait_to(0, 1'b1, lo);
            wait_to(0, 1'b1, lo);
            chk_n("channel period", f_per(i[0], n), lo);
        end
        wr(PMDC_OFF_PERIOD0, 32'h0);
        step(10);
        hi = 0;
        for (int i = 0; i < 100; i++) begin
            step(1);
            hi += int'(pwm_out[0] === 1'b1);
        end
        chk_n("period zero high cycles", 0, hi);
        $display("test frequency done");
        wr(PMDC_OFF_PERIOD0, 32'd20);
        // Channel 7 runs too so the match check sees traffic; the edge-ignore check never triggers, as zf[7] is set before each edge match
        wr(PMDC_OFF_PERIOD7, 32'd20);
        for (int i = 0; i < 5; i++) begin
            wr(PMDC_OFF_CTL2, zc_ctl[i]);
            wait_to(0, zc_first[i], n);
            wait_to(0, zc_first[i], n);
            wr(PMDC_OFF_FLAG, 32'h000000FF);
            wait_to(0, ~zc_first[i], n);
            step(3);
            apb(1'b0, PMDC_OFF_FLAG, 32'h0, rv, re);
            chk("zero flag", zc_exp[i], rv & 32'h1);
        end
        wr(PMDC_OFF_PERIOD7, 32'h0);
        $display("test zero point done");
        wr(PMDC_OFF_CTL2, 32'h0);
        wr(PMDC_OFF_PERIOD0, 32'd5);
        wr(PMDC_OFF_INTSTS, 32'h000000FF);
        wr(PMDC_OFF_INTEN, 32'h00000001);
        step(30);
        chk("irq enabled", 32'h1, {31'h0, irq});
        wr(PMDC_OFF_INTEN, 32'h0);
        step(3);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(PMDC_OFF_PERIOD0, 32'h0);
        step(10);
        wr(PMDC_OFF_INTSTS, 32'h000000FF);
        wr(PMDC_OFF_FLAG, 32'h000000FF);
        apb(1'b0, PMDC_OFF_FLAG, 32'h0, rv, re);
        chk("flag cleared", 32'h0, rv);
        apb(1'b0, PMDC_OFF_INTSTS, 32'h0, rv, re);
        chk("int flag cleared", 32'h0, rv);
        wr(PMDC_OFF_INTEN, 32'h00000001);
        step(3);
        chk("irq after clear", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        // Grouped channels follow channel 0 or 1, else their own period
        for (int c = 2; c < 6; c += 3) begin
            wr(PMDC_OFF_PERIOD0 + 8'(4 * (c % 2)), 32'd6);
            wr(PMDC_OFF_PERIOD0 + 8'(4 * c), 32'd11);
            for (int g = 1; g >= 0; g--) begin
                wr(PMDC_OFF_CTL2, g[0] ? 32'h40000000 : 32'h0);
                wait_to(c, 1'b1, n);
                wait_to(c, 1'b1, n);
                wait_to(c, 1'b1, n);
                chk_n("group period", f_per(0, g[0] ? 6 : 11), n);
            end
        end
        $display("test grouping done");
        for (int k = 0; k < 4; k++) begin
            wr(PMDC_OFF_PERIOD0 + 8'(8 * k), 32'd9);
            wr(PMDC_OFF_CTL2, 32'h10000000 | (32'h1 << (24 + k)));
            wait_to(2 * k + 1, 1'b1, n);
            wait_to(2 * k + 1, 1'b1, n);
            {lo, hi} = '0;
            for (int i = 0; i < 4 * f_per(0, 9); i++) begin
                step(1);
                lo += int'(pwm_out[2 * k] === 1'b0 && pwm_out[2 * k + 1] === 1'b0);
                hi += int'(pwm_out[2 * k] !== 1'b0 && pwm_out[2 * k + 1] !== 1'b0);
            end
            chk_n("dead time low cycles", 8 * DT, lo);
            chk_n("pair both high cycles", 0, hi);
        end
        $display("test dead time done");
        wr(PMDC_OFF_PERIOD1, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(PMDC_OFF_CTL2, 32'(m) << 28);
            step(30);
            bad = 0;
            for (int i = 0; i < 40; i++) begin
                step(1);
                bad += int'(pwm_out[1] !== f_odd(m, pwm_out[0]));
            end
            chk_n("mode odd output", 0, bad);
        end
        $display("test modes done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
